// ---- logic/tsra_pkg.sv ----
// Shared constants and types for the sensor register access block
package tsra_pkg;

	// ---------------------------------------------------------------
	// Selector codes
	// ---------------------------------------------------------------
	localparam logic [1:0] TSRA_PTR_TEMP = 2'h0;
	localparam logic [1:0] TSRA_PTR_CFG = 2'h1;
	localparam logic [1:0] TSRA_PTR_LOW = 2'h2;
	localparam logic [1:0] TSRA_PTR_HIGH = 2'h3;
	localparam logic [5:0] TSRA_PTR_UPPER_OK = 6'h00;

	// ---------------------------------------------------------------
	// Values after reset
	// ---------------------------------------------------------------
	localparam logic [1:0] TSRA_PTR_RST = 2'h0;
	localparam logic [15:0] TSRA_TEMP_RST = 16'h0000;
	localparam logic [6:0] TSRA_CFG_RST = 7'h00;
	localparam logic [15:0] TSRA_LOW_RST = 16'h4B00;
	localparam logic [15:0] TSRA_HIGH_RST = 16'h5000;

	// ---------------------------------------------------------------
	// Bus address and configuration field positions (upper byte)
	// ---------------------------------------------------------------
	localparam logic [3:0] TSRA_ADDR_PREFIX = 4'h9;
	localparam int TSRA_CFG_OS = 7;
	localparam int TSRA_CFG_RES_HI = 6;
	localparam int TSRA_CFG_RES_LO = 5;
	localparam int TSRA_CFG_FQ_HI = 4;
	localparam int TSRA_CFG_FQ_LO = 3;
	localparam int TSRA_CFG_POL = 2;
	localparam int TSRA_CFG_MODE = 1;
	localparam int TSRA_CFG_SD = 0;

	// ---------------------------------------------------------------
	// Result masks per resolution code, left justified
	// ---------------------------------------------------------------
	localparam logic [15:0] TSRA_MASK_9 = 16'hFF80;
	localparam logic [15:0] TSRA_MASK_10 = 16'hFFC0;
	localparam logic [15:0] TSRA_MASK_11 = 16'hFFE0;
	localparam logic [15:0] TSRA_MASK_12 = 16'hFFF0;

	// ---------------------------------------------------------------
	// Conversion times
	// ---------------------------------------------------------------
	localparam int TSRA_CLK_HZ = 100_000_000;
	localparam int TSRA_CONV9_MS = 25;
	localparam int TSRA_CONV10_MS = 50;
	localparam int TSRA_CONV11_MS = 100;
	localparam int TSRA_CONV12_MS = 200;
	localparam int TSRA_CYC_PER_MS = TSRA_CLK_HZ / 1000;
	localparam int TSRA_CONV9_CYC = TSRA_CONV9_MS * TSRA_CYC_PER_MS;
	localparam int TSRA_CONV10_CYC = TSRA_CONV10_MS * TSRA_CYC_PER_MS;
	localparam int TSRA_CONV11_CYC = TSRA_CONV11_MS * TSRA_CYC_PER_MS;
	localparam int TSRA_CONV12_CYC = TSRA_CONV12_MS * TSRA_CYC_PER_MS;

	// ---------------------------------------------------------------
	// Serial engine states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		TSRA_S_IDLE = 3'b000,
		TSRA_S_ADDR = 3'b001,
		TSRA_S_PTR = 3'b010,
		TSRA_S_WDATA = 3'b011,
		TSRA_S_ACK = 3'b100,
		TSRA_S_RD = 3'b101,
		TSRA_S_MACK = 3'b110
	} tsra_state_t;

endpackage

// ---- logic/tsra_conv_timer.sv ----
// Conversion period timer with one-shot support
`timescale 1ns/1ps
module tsra_conv_timer #(
	parameter int P_CYC9 = tsra_pkg::TSRA_CONV9_CYC,
	parameter int P_CYC10 = tsra_pkg::TSRA_CONV10_CYC,
	parameter int P_CYC11 = tsra_pkg::TSRA_CONV11_CYC,
	parameter int P_CYC12 = tsra_pkg::TSRA_CONV12_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic [1:0] i_res,
	input wire logic i_shutdown,
	input wire logic i_one_shot,
	// Result strobe
	output logic o_done
);
	import tsra_pkg::*;

	if (P_CYC9 < 1 || P_CYC10 < 1 || P_CYC11 < 1 || P_CYC12 < 1)
	begin : g_chk
		$error("conversion counts must be at least one cycle");
	end

	typedef struct packed {
		logic [31:0] cnt;
		logic os_run;
		logic done;
	} tsra_tmr_t;

	tsra_tmr_t r_ff;
	tsra_tmr_t nxt_r;
	logic [31:0] limit;

	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;
		unique case (i_res)
			2'h0: limit = 32'(P_CYC9);
			2'h1: limit = 32'(P_CYC10);
			2'h2: limit = 32'(P_CYC11);
			default: limit = 32'(P_CYC12);
		endcase
		// One-shot is meaningless unless shut down
		if (i_one_shot && i_shutdown)
			nxt_r.os_run = 1'b1;
		if (i_shutdown && !r_ff.os_run && !nxt_r.os_run)
			nxt_r.cnt = 32'h0;
		else if (r_ff.cnt >= limit - 32'h1)
		begin
			nxt_r.cnt = 32'h0;
			nxt_r.done = 1'b1;
			nxt_r.os_run = 1'b0;
		end
		else
			nxt_r.cnt = r_ff.cnt + 32'h1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign o_done = r_ff.done;

endmodule

// ---- logic/tsra_top.sv ----
// Serial register access layer of the temperature sensor
`timescale 1ns/1ps
// Operation
// - Five registers: write-only selector plus temp, config, low, high.
// - Selector codes 0..3 pick temp, config, low limit, high limit.
// - Selector persists across reads until a new selector write.
// - First byte after a write address is always the selector.
// - Invalid selector byte is acknowledged but leaves selector unchanged.
// - Address 1001AAA plus direction bit, AAA from strap pins.
// - Acknowledge after matching address and after each selector byte.
// - Selector resets to zero so temperature reads need no setup.
// - Result is 16-bit twos complement, unused low bits forced zero.
// - Bit 15 of the result is the sign.
// - Result left justified: 9 bits at 15:7 down to 15:4.
// - New conversion loads when no result read is in progress, or at a host ack after the lower byte.
// - Reading the result never disturbs background conversions.
// - Upper byte, host ack, lower byte, host nack, then release.
// - Host ack after lower byte restarts with fresh upper byte.
// - Host nack after upper byte skips lower byte and releases.
// - Result register resets to zero.
// - Writes aimed at the result are discarded with a nack.
// - Config is 16 bits; upper byte alone suffices to read and write.
// - Resolution codes 0..3 give 9..12 bits, 25 to 200 ms.
// - Only first config data byte counts; partial bytes change nothing.
module tsra_top #(
	parameter int P_CYC9 = tsra_pkg::TSRA_CONV9_CYC,
	parameter int P_CYC10 = tsra_pkg::TSRA_CONV10_CYC,
	parameter int P_CYC11 = tsra_pkg::TSRA_CONV11_CYC,
	parameter int P_CYC12 = tsra_pkg::TSRA_CONV12_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// Strap pins
	input wire logic [2:0] i_addr_select_pins,
	// Sensor sample, twos complement, bit 4 is one degree
	input wire logic [11:0] i_temp_sample,
	// Register contents toward the sensor core
	output logic [15:0] o_temp_value_bits,
	output logic [1:0] o_resolution_field,
	output logic [1:0] o_fault_queue,
	output logic o_alert_polarity,
	output logic o_alarm_mode,
	output logic o_shutdown,
	output logic o_conv_done,
	output logic [15:0] o_low_limit,
	output logic [15:0] o_high_limit
);
	import tsra_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		tsra_state_t st;
		tsra_state_t ack_next;
		logic scl_q;
		logic sda_q;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic got;
		logic oe_n;
		logic [1:0] idx;
		logic [1:0] ptr;
		logic wr_ok;
		logic mack;
		logic [6:0] cfg;
		logic [15:0] low;
		logic [15:0] high;
		logic [15:0] temp;
		logic pend;
		logic [15:0] pend_val;
		logic [2:0] addr;
		logic strap_done;
		logic os_go;
		logic conv_q;
	} tsra_regs_t;

	tsra_regs_t r_ff;
	tsra_regs_t nxt_r;
	logic conv_done;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic reading;
	logic [15:0] conv_val;
	logic [15:0] fresh;
	logic [7:0] byte_out;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] res_mask(input logic [1:0] res);
		logic [15:0] m;
		m = TSRA_MASK_12;
		unique case (res)
			2'h0: m = TSRA_MASK_9;
			2'h1: m = TSRA_MASK_10;
			2'h2: m = TSRA_MASK_11;
			default: m = TSRA_MASK_12;
		endcase
		return m;
	endfunction

	function automatic logic [7:0] rd_byte(input tsra_regs_t r,
		input logic [1:0] ptr, input logic [1:0] idx,
		input logic [15:0] t);
		logic [15:0] w;
		w = t;
		unique case (ptr)
			TSRA_PTR_TEMP: w = t;
			// One-shot bit and the reserved low byte read as zero
			TSRA_PTR_CFG: w = {1'b0, r.cfg, 8'h00};
			TSRA_PTR_LOW: w = r.low;
			default: w = r.high;
		endcase
		return (idx == 2'h0) ? w[15:8] : w[7:0];
	endfunction

	// ---------------------------------------------------------------
	// Conversion timing
	// ---------------------------------------------------------------
	// Timer runs free of the bus so reads cannot stall conversions
	// independent conversion timer
	tsra_conv_timer #(
		.P_CYC9(P_CYC9),
		.P_CYC10(P_CYC10),
		.P_CYC11(P_CYC11),
		.P_CYC12(P_CYC12)
	) u_timer (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_res(r_ff.cfg[TSRA_CFG_RES_HI:TSRA_CFG_RES_LO]),
		.i_shutdown(r_ff.cfg[TSRA_CFG_SD]),
		.i_one_shot(r_ff.os_go),
		.o_done(conv_done)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.scl_q = i_scl;
		nxt_r.sda_q = i_sda;
		nxt_r.os_go = 1'b0;
		nxt_r.conv_q = conv_done;
		scl_rise = i_scl && !r_ff.scl_q;
		scl_fall = !i_scl && r_ff.scl_q;
		bus_start = r_ff.scl_q && i_scl && r_ff.sda_q && !i_sda;
		bus_stop = r_ff.scl_q && i_scl && !r_ff.sda_q && i_sda;
		// Ack before the first read byte counts, so both bytes match
		reading = (r_ff.ptr == TSRA_PTR_TEMP) &&
			(r_ff.st == TSRA_S_RD || r_ff.st == TSRA_S_MACK ||
			(r_ff.st == TSRA_S_ACK && r_ff.ack_next == TSRA_S_RD));
		conv_val = {i_temp_sample, 4'h0} &
			res_mask(r_ff.cfg[TSRA_CFG_RES_HI:TSRA_CFG_RES_LO]);
		// A conversion ending right at the restart must not be lost
		fresh = conv_done ? conv_val :
			(r_ff.pend ? r_ff.pend_val : r_ff.temp);
		byte_out = 8'h00;
		// Straps are caught once, just after reset release
		if (!r_ff.strap_done)
		begin
			nxt_r.addr = i_addr_select_pins;
			nxt_r.strap_done = 1'b1;
		end
		// defer loading while a read is shifting out
		if (!reading && r_ff.pend)
		begin
			nxt_r.temp = r_ff.pend_val;
			nxt_r.pend = 1'b0;
		end
		if (conv_done)
		begin
			if (reading)
			begin
				nxt_r.pend = 1'b1;
				nxt_r.pend_val = conv_val;
			end
			else
			begin
				nxt_r.temp = conv_val;
				nxt_r.pend = 1'b0;
			end
		end
		if (bus_stop)
		begin
			nxt_r.st = TSRA_S_IDLE;
			nxt_r.oe_n = 1'b1;
		end
		else if (bus_start)
		begin
			nxt_r.st = TSRA_S_ADDR;
			nxt_r.cnt = 4'h0;
			nxt_r.got = 1'b0;
			nxt_r.oe_n = 1'b1;
		end
		else
		begin
			unique case (r_ff.st)
				TSRA_S_IDLE:
				begin
				end
				TSRA_S_ADDR, TSRA_S_PTR, TSRA_S_WDATA:
				begin
					// bytes act only once all eight bits are in
					if (scl_rise && !r_ff.got)
					begin
						nxt_r.sh = {r_ff.sh[6:0], i_sda};
						nxt_r.cnt = r_ff.cnt + 4'h1;
						if (r_ff.cnt == 4'h7)
							nxt_r.got = 1'b1;
					end
					if (scl_fall && r_ff.got)
					begin
						nxt_r.got = 1'b0;
						nxt_r.cnt = 4'h0;
						nxt_r.st = TSRA_S_ACK;
						nxt_r.oe_n = 1'b0;
						if (r_ff.st == TSRA_S_ADDR)
						begin
							if (r_ff.sh[7:1] == {TSRA_ADDR_PREFIX, r_ff.addr})
							begin
								nxt_r.idx = 2'h0;
								nxt_r.ack_next = r_ff.sh[0] ?
									TSRA_S_RD : TSRA_S_PTR;
							end
							else
							begin
								nxt_r.st = TSRA_S_IDLE;
								nxt_r.oe_n = 1'b1;
							end
						end
						else if (r_ff.st == TSRA_S_PTR)
						begin
							nxt_r.wr_ok = (r_ff.sh[7:2] == TSRA_PTR_UPPER_OK);
							if (r_ff.sh[7:2] == TSRA_PTR_UPPER_OK)
								nxt_r.ptr = r_ff.sh[1:0];
							nxt_r.idx = 2'h0;
							nxt_r.ack_next = TSRA_S_WDATA;
						end
						else if (r_ff.wr_ok && r_ff.ptr == TSRA_PTR_TEMP)
						begin
							nxt_r.oe_n = 1'b1;
							nxt_r.ack_next = TSRA_S_IDLE;
						end
						else
						begin
							nxt_r.ack_next = TSRA_S_WDATA;
							if (r_ff.idx != 2'h2)
								nxt_r.idx = r_ff.idx + 2'h1;
							if (r_ff.wr_ok)
							begin
								unique case (r_ff.ptr)
									TSRA_PTR_CFG:
									begin
										if (r_ff.idx == 2'h0)
										begin
											nxt_r.cfg = r_ff.sh[6:0];
											nxt_r.os_go = r_ff.sh[TSRA_CFG_OS] &&
												r_ff.cfg[TSRA_CFG_SD];
										end
									end
									TSRA_PTR_LOW:
									begin
										if (r_ff.idx == 2'h0)
											nxt_r.low[15:8] = r_ff.sh;
										else if (r_ff.idx == 2'h1)
											nxt_r.low[7:0] = r_ff.sh;
									end
									default:
									begin
										if (r_ff.idx == 2'h0)
											nxt_r.high[15:8] = r_ff.sh;
										else if (r_ff.idx == 2'h1)
											nxt_r.high[7:0] = r_ff.sh;
									end
								endcase
							end
						end
					end
				end
				TSRA_S_ACK:
				begin
					if (scl_fall)
					begin
						if (r_ff.ack_next == TSRA_S_RD)
						begin
							byte_out = rd_byte(r_ff, r_ff.ptr, 2'h0, r_ff.temp);
							nxt_r.oe_n = byte_out[7];
							nxt_r.tx = {byte_out[6:0], 1'b0};
							nxt_r.cnt = 4'h1;
						end
						else
						begin
							nxt_r.oe_n = 1'b1;
							nxt_r.cnt = 4'h0;
							nxt_r.got = 1'b0;
						end
						nxt_r.st = r_ff.ack_next;
					end
				end
				TSRA_S_RD:
				begin
					if (scl_fall)
					begin
						if (r_ff.cnt == 4'h8)
						begin
							nxt_r.oe_n = 1'b1;
							nxt_r.st = TSRA_S_MACK;
						end
						else
						begin
							nxt_r.oe_n = r_ff.tx[7];
							nxt_r.tx = {r_ff.tx[6:0], 1'b0};
							nxt_r.cnt = r_ff.cnt + 4'h1;
						end
					end
				end
				TSRA_S_MACK:
				begin
					if (scl_rise)
						nxt_r.mack = !i_sda;
					if (scl_fall)
					begin
						if (!r_ff.mack)
						begin
							nxt_r.st = TSRA_S_IDLE;
							nxt_r.oe_n = 1'b1;
						end
						else
						begin
							// ack after lower byte sends fresh data
							if (r_ff.idx == 2'h1 && r_ff.ptr == TSRA_PTR_TEMP)
							begin
								nxt_r.temp = fresh;
								nxt_r.pend = 1'b0;
							end
							nxt_r.idx = (r_ff.idx == 2'h0) ? 2'h1 : 2'h0;
							// Lower byte belongs to the word already started
							byte_out = rd_byte(r_ff, r_ff.ptr, nxt_r.idx,
								(r_ff.idx == 2'h1) ? fresh : r_ff.temp);
							nxt_r.oe_n = byte_out[7];
							nxt_r.tx = {byte_out[6:0], 1'b0};
							nxt_r.cnt = 4'h1;
							nxt_r.st = TSRA_S_RD;
						end
					end
				end
				default:
				begin
					nxt_r.st = TSRA_S_IDLE;
					nxt_r.oe_n = 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r_ff <= '0;
			r_ff.st <= TSRA_S_IDLE;
			r_ff.ack_next <= TSRA_S_IDLE;
			r_ff.scl_q <= 1'b1;
			r_ff.sda_q <= 1'b1;
			r_ff.oe_n <= 1'b1;
			r_ff.ptr <= TSRA_PTR_RST;
			r_ff.temp <= TSRA_TEMP_RST;
			r_ff.cfg <= TSRA_CFG_RST;
			r_ff.low <= TSRA_LOW_RST;
			r_ff.high <= TSRA_HIGH_RST;
		end
		else
			r_ff <= nxt_r;
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe_n = r_ff.oe_n;
	assign o_temp_value_bits = r_ff.temp;
	assign o_resolution_field = r_ff.cfg[TSRA_CFG_RES_HI:TSRA_CFG_RES_LO];
	assign o_fault_queue = r_ff.cfg[TSRA_CFG_FQ_HI:TSRA_CFG_FQ_LO];
	assign o_alert_polarity = r_ff.cfg[TSRA_CFG_POL];
	assign o_alarm_mode = r_ff.cfg[TSRA_CFG_MODE];
	assign o_shutdown = r_ff.cfg[TSRA_CFG_SD];
	assign o_conv_done = r_ff.conv_q;
	assign o_low_limit = r_ff.low;
	assign o_high_limit = r_ff.high;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_byte_done(tsra_state_t s);
		r_ff.st == s && scl_fall && r_ff.got && !bus_start && !bus_stop;
	endsequence

	sequence s_addr_hit;
		s_byte_done(TSRA_S_ADDR) ##0
			(r_ff.sh[7:1] == {TSRA_ADDR_PREFIX, r_ff.addr});
	endsequence

	a_addr_ack: assert property (
		s_addr_hit |=> !r_ff.oe_n && r_ff.st == TSRA_S_ACK)
		else $error("matching address not acknowledged");
	a_ptr_hold: assert property (
		$changed(r_ff.ptr) |-> $past(r_ff.st) == TSRA_S_PTR)
		else $error("selector changed outside a selector byte");
	a_bad_ptr: assert property (
		s_byte_done(TSRA_S_PTR) ##0 (r_ff.sh[7:2] != 6'h00)
		|=> $stable(r_ff.ptr) && !r_ff.oe_n)
		else $error("invalid selector not ignored with ack");
	a_temp_nack: assert property (
		s_byte_done(TSRA_S_WDATA) ##0 (r_ff.wr_ok &&
		r_ff.ptr == TSRA_PTR_TEMP) |=> r_ff.oe_n &&
		(r_ff.conv_q || $stable(r_ff.temp)))
		else $error("write to result not refused");
	a_low_zero: assert property (
		r_ff.temp[3:0] == 4'h0)
		else $error("result low nibble not zero");
	a_read_frozen: assert property (
		r_ff.st == TSRA_S_RD && r_ff.ptr == TSRA_PTR_TEMP
		|=> $stable(r_ff.temp))
		else $error("result changed during a read");
	a_conv_load: assert property (
		conv_done && !reading && !bus_start && !bus_stop |=>
		r_ff.temp == ($past(conv_val)))
		else $error("conversion not loaded");
	a_nack_end: assert property (
		r_ff.st == TSRA_S_MACK && scl_fall && !r_ff.mack &&
		!bus_start && !bus_stop |=> r_ff.st == TSRA_S_IDLE ##0 r_ff.oe_n)
		else $error("line not released after host nack");
	a_ack_repeat: assert property (
		r_ff.st == TSRA_S_MACK && scl_fall && r_ff.mack &&
		r_ff.idx == 2'h1 && !bus_start && !bus_stop
		|=> r_ff.st == TSRA_S_RD && r_ff.idx == 2'h0)
		else $error("no restart with upper byte");

endmodule

// ---- test/tsra_i2c_master.sv ----
// Serial bus host model for the sensor register access block
`timescale 1ns/1ps
module tsra_i2c_master (
	// Clock
	input wire logic i_clk,
	// Device drive of the data line
	input wire logic i_sda_out,
	input wire logic i_sda_oe_n,
	// Bus lines
	output logic o_scl,
	output logic o_sda
);
	logic sda_drv;

	// Pull-up on the data line: released reads high, any pull wins
	assign o_sda = sda_drv & (i_sda_oe_n | i_sda_out);

	initial
	begin
		o_scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic start();
		sda_drv <= 1'b1;
		wait_clk(2);
		o_scl <= 1'b1;
		wait_clk(4);
		sda_drv <= 1'b0;
		wait_clk(4);
	endtask

	// Data changes only while the clock is low; sampled while high
	task automatic bit_io(input logic b, output logic r);
		o_scl <= 1'b0;
		wait_clk(2);
		sda_drv <= b;
		wait_clk(2);
		o_scl <= 1'b1;
		wait_clk(2);
		r = o_sda;
		wait_clk(2);
	endtask

	// host ack or nack in the ninth bit
	task automatic xfer(input logic [7:0] wb, input logic ack_in,
		output logic [7:0] rb, output logic ack_out);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(wb[i], r);
			rb[i] = r;
		end
		bit_io(ack_in, ack_out);
	endtask

	task automatic stop();
		o_scl <= 1'b0;
		wait_clk(2);
		sda_drv <= 1'b0;
		wait_clk(2);
		o_scl <= 1'b1;
		wait_clk(4);
		sda_drv <= 1'b1;
		wait_clk(4);
	endtask
endmodule

// ---- test/test_tsra_top.sv ----
// Self-checking bench for the sensor register access block
`timescale 1ns/1ps
module test_tsra_top;
	import tsra_pkg::*;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [7:0] ADDR_W = {TSRA_ADDR_PREFIX, STRAP, 1'b0};
	localparam logic [7:0] ADDR_R = {TSRA_ADDR_PREFIX, STRAP, 1'b1};
	localparam logic [15:0] MASKS [4] = '{TSRA_MASK_9, TSRA_MASK_10,
		TSRA_MASK_11, TSRA_MASK_12};
	logic i_clk, i_rst_n, scl, sda, sda_out, sda_oe_n, conv_done, k;
	logic [11:0] i_temp_sample, next_sample;
	logic [15:0] temp_bits, low_lim, high_lim, rd;
	logic [1:0] res_field, fq;
	logic pol, amode, sd_on;
	logic [4:0] a;
	logic [7:0] x, cb;
	int error_cnt, n_tests;

	tsra_top #(.P_CYC9(50), .P_CYC10(100), .P_CYC11(150), .P_CYC12(200))
	u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_addr_select_pins(STRAP), .i_temp_sample(i_temp_sample),
		.o_temp_value_bits(temp_bits), .o_resolution_field(res_field),
		.o_fault_queue(fq), .o_alert_polarity(pol),
		.o_alarm_mode(amode), .o_shutdown(sd_on),
		.o_conv_done(conv_done), .o_low_limit(low_lim),
		.o_high_limit(high_lim));

	tsra_i2c_master u_mst (.i_clk(i_clk), .i_sda_out(sda_out),
		.i_sda_oe_n(sda_oe_n), .o_scl(scl), .o_sda(sda));

	// ---------------------------------------------------------------
	// Bench tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic set_temp(input logic [11:0] v);
		i_temp_sample <= v;
		next_sample = v;
	endtask

	// Bounded wait for one conversion strobe, sampled off the edge
	task automatic wait_conv();
		int n;
		n = 0;
		@(negedge i_clk);
		while (conv_done !== 1'b1 && n < 1000)
		begin
			@(negedge i_clk);
			n++;
		end
		check({15'h0000, conv_done}, 16'h0001);
		@(posedge i_clk);
	endtask

	// Acks come back as {addr, selector, data0..2}, one means nack
	task automatic wr(input logic [7:0] sel, input int n,
		input logic [23:0] d);
		a = 5'h00;
		u_mst.start();
		u_mst.xfer(ADDR_W, 1'b1, x, a[4]);
		u_mst.xfer(sel, 1'b1, x, a[3]);
		for (int i = 0; i < n; i++)
			u_mst.xfer(d[23 - 8 * i -: 8], 1'b1, x, a[2 - i]);
		u_mst.stop();
	endtask

	// Host acks every byte but the last; sample may change mid-read
	task automatic rdn(input int n, output logic [15:0] v);
		v = 16'h0000;
		u_mst.start();
		u_mst.xfer(ADDR_R, 1'b1, x, k);
		check({15'h0000, k}, 16'h0000);
		for (int i = 0; i < n; i++)
		begin
			u_mst.xfer(8'hFF, (i == n - 1), x, k);
			v = {v[7:0], x};
			if (i == 0)
				i_temp_sample <= next_sample;
		end
		u_mst.stop();
		check({15'h0000, sda}, 16'h0001);
	endtask

	// ---------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ---------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Whole run needs roughly 10k cycles; 30k means a hang
	initial
	begin
		#300000;
		error_cnt++;
		finish_test();
	end

	initial
	begin
		error_cnt = 0;
		n_tests = 0;
		i_rst_n = 1'b0;
		i_temp_sample = 12'hF5E;
		next_sample = 12'hF5E;
		repeat (8) @(posedge i_clk);
		check(temp_bits, 16'h0000);
		check(low_lim, 16'h4B00);
		check(high_lim, 16'h5000);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		wait_conv();
		rdn(2, rd);
		check(rd, 16'hF580);
		set_temp(12'hFFF);
		for (int r = 0; r < 4; r++)
		begin
			cb = {1'b0, 2'(r), 5'h00};
			wr(8'h01, 1, {cb, 16'h0000});
			check({11'h000, a}, 16'h0000);
			check({14'h0000, res_field}, 16'(r));
			rdn(2, rd);
			check(rd, {cb, 8'h00});
			wr(8'h00, 0, 24'h000000);
			wait_conv();
			wait_conv();
			rdn(2, rd);
			check(rd, 16'hFFF0 & MASKS[r]);
		end
		// Shutdown holds conversions; one-shot runs exactly one
		wr(8'h01, 1, 24'h1F0000);
		check({11'h000, fq, pol, amode, sd_on}, 16'h001F);
		wr(8'h01, 1, 24'h9F0000);
		wait_conv();
		check(temp_bits, 16'hFF80);
		rdn(2, rd);
		check(rd, 16'h1F00);
		wr(8'h01, 1, 24'h000000);
		wr(8'h02, 2, 24'h123400);
		check(low_lim, 16'h1234);
		wr(8'h03, 3, 24'hA5C3FF);
		check({11'h000, a}, 16'h0000);
		check(high_lim, 16'hA5C3);
		rdn(2, rd);
		check(rd, 16'hA5C3);
		rdn(2, rd);
		check(rd, 16'hA5C3);
		wr(8'h06, 0, 24'h000000);
		check({11'h000, a}, 16'h0000);
		rdn(2, rd);
		check(rd, 16'hA5C3);
		wr(8'h02, 0, 24'h000000);
		rdn(2, rd);
		check(rd, 16'h1234);
		wr(8'h00, 1, 24'h7F0000);
		check({11'h000, a}, 16'h0004);
		u_mst.start();
		u_mst.xfer({TSRA_ADDR_PREFIX, ~STRAP, 1'b1}, 1'b1, x, k);
		u_mst.stop();
		check({15'h0000, k}, 16'h0001);
		// Configuration byte cut short by stop is dropped
		u_mst.start();
		u_mst.xfer(ADDR_W, 1'b1, x, k);
		u_mst.xfer(8'h01, 1'b1, x, k);
		repeat (4) u_mst.bit_io(1'b1, k);
		u_mst.stop();
		rdn(2, rd);
		check(rd, 16'h0000);
		check({14'h0000, res_field}, 16'h0000);
		wr(8'h00, 0, 24'h000000);
		set_temp(12'hF5E);
		wait_conv();
		next_sample = 12'h191;
		rdn(3, rd);
		check(rd, 16'h8019);
		rdn(1, rd);
		check(rd, 16'h0019);
		finish_test();
	end
endmodule
